/* File: src/ptor_regs.sv */
`timescale 1ns/100ps
// How it works
// (RULE1) Altitude when selected, otherwise pressure in place
// (RULE2) Altitude is signed Q16.4, fraction in top nibble
// (RULE3) Pressure is unsigned Q18.2, fraction in bits 5..4
// (RULE4) Raw mode fills all 24 pressure bits
// (RULE5) Status and samples at auto-incrementing addresses 00h-05h
// (RULE6) Temperature is signed Q8.4, fraction in top nibble
// (RULE7) Raw mode fills all 16 temperature bits
// (RULE8) Delta holds difference of two latest samples
// (RULE9) Altitude delta signed, fraction in bits 7..4
// (RULE10) Pressure delta unsigned, fraction in bits 5..4
// (RULE11) Raw mode leaves delta registers untouched
// (RULE12) Delta updates whatever the FIFO output mode
// (RULE13) Read-only, writes ignored, zero after reset
// (RULE14) FIFO mode blanks middle, low and temperature reads
// (RULE15) High byte read clears overwrite flag, FIFO off
module ptor_regs import ptor_pkg::*; (
    input wire logic CLK,
    input wire logic RESET_N,
    // Acquisition side
    input wire logic PRESS_VALID,
    input wire logic [23:0] PRESS_DATA,
    input wire logic TEMP_VALID,
    input wire logic [15:0] TEMP_DATA,
    // Mode settings from elsewhere in the device
    input wire logic ALTITUDE_SELECT,
    input wire logic RAW_SELECT,
    input wire logic [1:0] FIFO_MODE,
    // Bytes owned by neighbouring blocks
    input wire logic [7:0] STATUS_BYTE,
    input wire logic [7:0] FIFO_BYTE,
    // Register port from the serial interface
    input wire logic ADDR_LOAD,
    input wire logic [7:0] LOAD_ADDR,
    input wire logic RD_STROBE,
    input wire logic WR_STROBE,
    input wire logic [7:0] WR_DATA,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output logic OVERWRITE_CLEAR
);
    logic [23:0] pa_q; // High, middle, low pressure/altitude bytes
    logic [15:0] tmp_q; // High, low temperature bytes
    logic [23:0] pc_q; // High, middle, low delta bytes
    logic [7:0] ptr_q; // Auto-incrementing register pointer
    logic [7:0] rdata_q; // Read answer
    logic rvalid_q; // Read answer valid pulse
    logic ovw_clr_q; // Overwrite flag clear pulse
    logic altitude_q; // Mode of the previous cycle
    logic fifo_on; // FIFO output mode is active
    logic [7:0] rd_byte; // Byte addressed by the pointer
    logic [PTOR_PA_W-1:0] delta_diff; // Raw difference
    logic delta_upd; // Delta register load

    assign fifo_on = (FIFO_MODE != PTOR_FMODE_OFF);

    // Addresses that read as zero while the FIFO port is active
    function automatic logic ptor_blanked(input logic [7:0] a);
        ptor_blanked = (a >= PTOR_ADDR_PA_MID) && (a <= PTOR_ADDR_T_LOW);
    endfunction

    // Pointer stays on the FIFO byte while the FIFO is drained
    function automatic logic ptor_fifo_hold(input logic [7:0] a,
                                           input logic on);
        ptor_fifo_hold = on && (a == PTOR_ADDR_PA_HIGH);
    endfunction

    // Track the altitude setting to notice mode changes
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            altitude_q <= 1'b0;
        end else begin
            altitude_q <= ALTITUDE_SELECT;
        end
    end

    // Pressure/altitude sample bytes
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pa_q <= PTOR_RESET_PA; // [RULE13]
        end else if (PRESS_VALID) begin
            if (RAW_SELECT) begin
                // Unprocessed result uses every bit
                pa_q <= PRESS_DATA; // [RULE4]
            end else begin
                // Both fixed-point forms share this byte layout;
                // only the sign and the binary point position differ
                pa_q <= {PRESS_DATA[19:0], PTOR_RSVD_NIB}; // [RULE1] [RULE2] [RULE3]
            end
        end
    end

    // Temperature sample bytes
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tmp_q <= PTOR_RESET_T; // [RULE13]
        end else if (TEMP_VALID) begin
            if (RAW_SELECT) begin
                tmp_q <= TEMP_DATA; // [RULE7]
            end else begin
                tmp_q <= {TEMP_DATA[11:0], PTOR_RSVD_NIB}; // [RULE6]
            end
        end
    end

    // Difference engine; raw mode and a mode change restart it
    ptor_delta #(
        .W(PTOR_PA_W)
    ) u_delta (
        .clk(CLK),
        .reset_n(RESET_N),
        .sample_valid(PRESS_VALID),
        .sample(PRESS_DATA[19:0]),
        .restart(RAW_SELECT || (ALTITUDE_SELECT != altitude_q)),
        .diff(delta_diff),
        .upd(delta_upd)
    );

    // Delta bytes; FIFO mode plays no part here
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pc_q <= PTOR_RESET_PA; // [RULE13]
        end else if (delta_upd) begin
            // Signed altitude or unsigned pressure share one layout
            pc_q <= {delta_diff, PTOR_RSVD_NIB}; // [RULE8] [RULE9] [RULE10] [RULE12]
        end
        // No load while raw mode holds the restart high [RULE11]
    end

    // Byte at the pointer, blanked in FIFO mode
    always_comb begin
        rd_byte = PTOR_RESET_BYTE;
        if (fifo_on && ptor_blanked(ptr_q)) begin
            rd_byte = PTOR_RESET_BYTE; // [RULE14]
        end else begin
            case (ptr_q)
                PTOR_ADDR_STATUS: rd_byte = STATUS_BYTE; // [RULE5]
                PTOR_ADDR_PA_HIGH: begin
                    rd_byte = fifo_on ? FIFO_BYTE : pa_q[23:16];
                end
                PTOR_ADDR_PA_MID: rd_byte = pa_q[15:8];
                PTOR_ADDR_PA_LOW: rd_byte = pa_q[7:0];
                PTOR_ADDR_T_HIGH: rd_byte = tmp_q[15:8];
                PTOR_ADDR_T_LOW: rd_byte = tmp_q[7:0];
                PTOR_ADDR_PC_HIGH: rd_byte = pc_q[23:16];
                PTOR_ADDR_PC_MID: rd_byte = pc_q[15:8];
                PTOR_ADDR_PC_LOW: rd_byte = pc_q[7:0];
                // Unmapped bytes read as zero
                default: rd_byte = PTOR_RESET_BYTE;
            endcase
        end
    end

    // Register pointer; every access advances it, except on the high byte while the FIFO port is on
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ptr_q <= PTOR_ADDR_STATUS;
        end else if (ADDR_LOAD) begin
            // Load wins; an access in the same cycle uses the old value
            ptr_q <= LOAD_ADDR;
        end else if ((RD_STROBE || WR_STROBE) &&
                     !ptor_fifo_hold(ptr_q, fifo_on)) begin
            ptr_q <= ptr_q + 8'h01; // [RULE5]
        end
    end

    // Read answer, one edge after the strobe
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_q <= PTOR_RESET_BYTE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= RD_STROBE;
            if (RD_STROBE) begin
                rdata_q <= rd_byte;
            end
        end
    end

    // Overwrite flag clear on a high-byte read with the FIFO off
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ovw_clr_q <= 1'b0;
        end else begin
            ovw_clr_q <= RD_STROBE && !fifo_on &&
                         (ptr_q == PTOR_ADDR_PA_HIGH); // [RULE15]
        end
    end

    // Write data has no destination: every byte here is read-only
    // [RULE13]
    logic wr_unused;
    assign wr_unused = ^WR_DATA;

    assign RD_DATA = rdata_q;
    assign RD_VALID = rvalid_q;
    assign OVERWRITE_CLEAR = ovw_clr_q;

    // Checking helpers: last processed sample seen
    logic [19:0] ast_last_q;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ast_last_q <= PTOR_RESET_SAMPLE;
        end else if (PRESS_VALID && !RAW_SELECT) begin
            ast_last_q <= PRESS_DATA[19:0];
        end
    end

    default clocking ck @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_press_layout: assert property ( // [RULE1] [RULE2] [RULE3]
        PRESS_VALID && !RAW_SELECT |=>
        pa_q == {$past(PRESS_DATA[19:0]), 4'h0})
        else $error("processed pressure layout wrong");

    a_press_raw: assert property ( // [RULE4]
        PRESS_VALID && RAW_SELECT |=> pa_q == $past(PRESS_DATA))
        else $error("raw pressure not stored whole");

    a_temp_layout: assert property ( // [RULE6]
        TEMP_VALID && !RAW_SELECT |=>
        tmp_q == {$past(TEMP_DATA[11:0]), 4'h0})
        else $error("processed temperature layout wrong");

    a_temp_raw: assert property ( // [RULE7]
        TEMP_VALID && RAW_SELECT |=> tmp_q == $past(TEMP_DATA))
        else $error("raw temperature not stored whole");

    a_delta_value: assert property ( // [RULE8] [RULE12]
        delta_upd |=> pc_q[23:4] ==
        20'($past(PRESS_DATA[19:0]) - $past(ast_last_q)))
        else $error("delta is not the sample difference");

    a_delta_frozen: assert property ( // [RULE11]
        RAW_SELECT |=> $stable(pc_q))
        else $error("delta changed in raw mode");

    a_write_ignored: assert property ( // [RULE13]
        WR_STROBE && !PRESS_VALID && !TEMP_VALID |=>
        $stable(pa_q) && $stable(tmp_q))
        else $error("write altered a sample byte");

    a_ptr_advance: assert property ( // [RULE5]
        RD_STROBE && !ADDR_LOAD && !fifo_on |=>
        ptr_q == 8'($past(ptr_q) + 8'h01))
        else $error("pointer did not auto-increment");

    a_fifo_blank: assert property ( // [RULE14]
        RD_STROBE && fifo_on && ptor_blanked(ptr_q) |=>
        RD_VALID && RD_DATA == 8'h00)
        else $error("blanked byte read nonzero");

    a_ovw_clear: assert property ( // [RULE15]
        RD_STROBE && !fifo_on && ptr_q == PTOR_ADDR_PA_HIGH |=>
        OVERWRITE_CLEAR ##1 !OVERWRITE_CLEAR || RD_STROBE)
        else $error("overwrite clear missing");

    a_ovw_quiet: assert property ( // [RULE15]
        !(RD_STROBE && ptr_q == PTOR_ADDR_PA_HIGH) |=> !OVERWRITE_CLEAR)
        else $error("spurious overwrite clear");

    // FIFO reads own the flag clearing, so no pulse here
    a_ovw_fifo: assert property ( // [RULE15]
        RD_STROBE && fifo_on |=> !OVERWRITE_CLEAR)
        else $error("overwrite clear during FIFO read");

    // Every read strobe is answered exactly one edge later
    a_rvalid_pulse: assert property ( // [RULE5]
        RD_STROBE |=> RD_VALID)
        else $error("read answer missing");

    // No answer without a read; writes stay silent
    a_rvalid_quiet: assert property ( // [RULE5] [RULE13]
        !RD_STROBE |=> !RD_VALID)
        else $error("read answer without a read");

    // First byte of a burst from 00h is the status byte
    a_read_status: assert property ( // [RULE5]
        RD_STROBE && ptr_q == PTOR_ADDR_STATUS |=>
        RD_DATA == $past(STATUS_BYTE))
        else $error("status byte not returned");

    // Middle sample byte follows the high one in the burst
    a_read_middle: assert property ( // [RULE5]
        RD_STROBE && !fifo_on && ptr_q == PTOR_ADDR_PA_MID |=>
        RD_DATA == $past(pa_q[15:8]))
        else $error("middle sample byte wrong");

    // Low delta byte carries the fraction and the reserved nibble
    a_read_delta: assert property ( // [RULE9] [RULE10]
        RD_STROBE && ptr_q == PTOR_ADDR_PC_LOW |=>
        RD_DATA == $past(pc_q[7:0]))
        else $error("low delta byte wrong");

    // The gap between temperature and delta reads as zero
    a_unmapped_zero: assert property ( // [RULE5]
        RD_STROBE && ptr_q == 8'h06 |=> RD_DATA == 8'h00)
        else $error("unmapped byte read nonzero");

    // FIFO data replaces the high byte while the port is on
    a_fifo_byte: assert property ( // [RULE14]
        RD_STROBE && fifo_on && ptr_q == PTOR_ADDR_PA_HIGH |=>
        RD_DATA == $past(FIFO_BYTE))
        else $error("FIFO byte not returned");

    // A FIFO drain keeps hitting the same address
    a_fifo_hold: assert property ( // [RULE14]
        RD_STROBE && !ADDR_LOAD && fifo_on &&
        ptr_q == PTOR_ADDR_PA_HIGH |=> ptr_q == PTOR_ADDR_PA_HIGH)
        else $error("pointer left the FIFO byte");

    // A mode change must not mix units in one difference
    a_delta_restart: assert property ( // [RULE8]
        ALTITUDE_SELECT != altitude_q |=> $stable(pc_q))
        else $error("delta loaded across a mode change");

    // Raw mode never requests a delta load
    a_raw_no_delta: assert property ( // [RULE11]
        RAW_SELECT |-> !delta_upd)
        else $error("delta load requested in raw mode");

    // Reserved pressure bits stay clear outside raw mode
    a_press_nibble: assert property ( // [RULE2] [RULE3]
        PRESS_VALID && !RAW_SELECT |=> pa_q[3:0] == 4'h0)
        else $error("reserved pressure bits set");

    // Reserved temperature bits stay clear outside raw mode
    a_temp_nibble: assert property ( // [RULE6]
        TEMP_VALID && !RAW_SELECT |=> tmp_q[3:0] == 4'h0)
        else $error("reserved temperature bits set");

    c_raw_sample: cover property (PRESS_VALID && RAW_SELECT);
    c_fifo_read: cover property (RD_STROBE && fifo_on);
    c_burst_end: cover property (
        RD_STROBE && ptr_q == PTOR_ADDR_T_LOW ##1 RD_VALID);
    c_delta_altitude: cover property (delta_upd && ALTITUDE_SELECT);
endmodule

/* File: src/ptor_pkg.sv */
package ptor_pkg;
    // Register offsets, one byte each, auto-incrementing
    localparam logic [7:0] PTOR_ADDR_STATUS = 8'h00;
    localparam logic [7:0] PTOR_ADDR_PA_HIGH = 8'h01;
    localparam logic [7:0] PTOR_ADDR_PA_MID = 8'h02;
    localparam logic [7:0] PTOR_ADDR_PA_LOW = 8'h03;
    localparam logic [7:0] PTOR_ADDR_T_HIGH = 8'h04;
    localparam logic [7:0] PTOR_ADDR_T_LOW = 8'h05;
    localparam logic [7:0] PTOR_ADDR_PC_HIGH = 8'h07;
    localparam logic [7:0] PTOR_ADDR_PC_MID = 8'h08;
    localparam logic [7:0] PTOR_ADDR_PC_LOW = 8'h09;
    // Value of every sample byte after reset and of blanked reads
    localparam logic [7:0] PTOR_RESET_BYTE = 8'h00;
    localparam logic [23:0] PTOR_RESET_PA = 24'h000000;
    localparam logic [15:0] PTOR_RESET_T = 16'h0000;
    localparam logic [19:0] PTOR_RESET_SAMPLE = 20'h00000;
    // Processed sample widths and the reserved low nibble
    localparam int PTOR_PA_W = 20;
    localparam int PTOR_T_W = 12;
    localparam logic [3:0] PTOR_RSVD_NIB = 4'h0;
    // Output mode value that means the FIFO port is off
    localparam logic [1:0] PTOR_FMODE_OFF = 2'h0;
    // Read data appears this many edges after the strobe
    localparam int PTOR_READ_LAT = 1;
endpackage

/* File: src/ptor_delta.sv */
`timescale 1ns/100ps
// Difference between the two latest processed pressure/altitude samples
module ptor_delta import ptor_pkg::*; #(
    parameter int W = PTOR_PA_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sample_valid,
    input wire logic [W-1:0] sample,
    input wire logic restart,
    output logic [W-1:0] diff,
    output logic upd
);
    logic [W-1:0] prev_q; // Last processed sample
    logic have_q; // A previous sample of this mode exists

    // Keep the last sample; a mode change or raw mode forgets it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= '0;
            have_q <= 1'b0;
        end else if (restart) begin
            // Mixing units across modes would give a meaningless step
            have_q <= 1'b0;
        end else if (sample_valid) begin
            prev_q <= sample;
            have_q <= 1'b1;
        end
    end

    // Two's complement wrap suits both the signed and unsigned form
    always_comb begin
        diff = W'(sample - prev_q);
        upd = sample_valid && have_q && !restart;
    end
endmodule

/* File: testbench/ptor_host_model.sv */
`timescale 1ns/100ps
// Host behind the serial interface: loads the pointer, then reads or writes
module ptor_host_model (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic ovw_clear,
    output logic addr_load = 1'b0,
    output logic [7:0] load_addr = 8'h00,
    output logic rd_strobe = 1'b0,
    output logic wr_strobe = 1'b0,
    output logic [7:0] wr_data = 8'hFF
);
    // Pointer load, then n back-to-back reads with the strobe held throughout
    task automatic burst(input logic [7:0] a, input int n,
                         output logic [7:0] d [10], output logic [9:0] p,
                         output bit ok);
        ok = 1'b1;
        p = 10'h000;
        @(negedge clk);
        addr_load = 1'b1;
        load_addr = a;
        @(negedge clk);
        addr_load = 1'b0;
        rd_strobe = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            // Last answer is taken at the same edge that drops the strobe
            if (i == n - 1) rd_strobe = 1'b0;
            ok &= (rd_valid === 1'b1);
            d[i] = rd_data;
            p[i] = ovw_clear;
        end
    endtask

    // Pointer load first, since a load and an access together use the old one
    task automatic write(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        addr_load = 1'b1;
        load_addr = a;
        @(negedge clk);
        addr_load = 1'b0;
        wr_strobe = 1'b1;
        wr_data = v;
        @(negedge clk);
        wr_strobe = 1'b0;
        // Released data must not keep showing the last value
        wr_data = ~v;
    endtask
endmodule

/* File: testbench/pressure_temp_output_regs_tb.sv */
`timescale 1ns/100ps
module pressure_temp_output_regs_tb import ptor_pkg::*;;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic press_valid = 1'b0;
    logic temp_valid = 1'b0;
    logic altitude = 1'b0;
    logic raw = 1'b0;
    logic [23:0] press_data = 24'h000000;
    logic [15:0] temp_data = 16'h0000;
    logic [1:0] fifo_mode = 2'h0;
    logic [7:0] status_byte = 8'h5A;
    logic [7:0] fifo_byte = 8'h3C;
    logic addr_load, rd_strobe, wr_strobe, rd_valid, ovw_clear;
    logic [7:0] load_addr, wr_data, rd_data;
    int n_mismatch = 0;
    int compares = 0;

    ptor_regs u_dut (.CLK(clk), .RESET_N(reset_n),
        .PRESS_VALID(press_valid), .PRESS_DATA(press_data),
        .TEMP_VALID(temp_valid), .TEMP_DATA(temp_data),
        .ALTITUDE_SELECT(altitude), .RAW_SELECT(raw), .FIFO_MODE(fifo_mode),
        .STATUS_BYTE(status_byte), .FIFO_BYTE(fifo_byte),
        .ADDR_LOAD(addr_load), .LOAD_ADDR(load_addr), .RD_STROBE(rd_strobe),
        .WR_STROBE(wr_strobe), .WR_DATA(wr_data), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .OVERWRITE_CLEAR(ovw_clear));

    ptor_host_model u_host (.clk(clk), .rd_data(rd_data),
        .rd_valid(rd_valid), .ovw_clear(ovw_clear), .addr_load(addr_load),
        .load_addr(load_addr), .rd_strobe(rd_strobe),
        .wr_strobe(wr_strobe), .wr_data(wr_data));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Single place where the run ends
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Byte compare, four-state exact
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Burst read; e holds bytes first-read-highest, ep the clear pulses
    task automatic rdchk(input logic [7:0] a, input int n,
                         input logic [79:0] e, input logic [9:0] ep);
        logic [7:0] d [10];
        logic [9:0] p;
        bit ok;
        u_host.burst(a, n, d, p, ok);
        if (!ok) begin
            n_mismatch++;
            $display("MISMATCH read answer at %h missing", a);
        end else begin
            for (int i = 0; i < n; i++) begin
                chk($sformatf("byte %h", a + i), e[8*(n-1-i) +: 8], d[i]);
                chk("overwrite clear", {7'h00, ep[i]}, {7'h00, p[i]});
            end
        end
    endtask

    // One-cycle acquisition pulses, launched off the sampling edge
    task automatic sample(input logic [23:0] pd, input logic pv,
                          input logic [15:0] td, input logic tv);
        @(negedge clk);
        press_data = pd;
        press_valid = pv;
        temp_data = td;
        temp_valid = tv;
        @(negedge clk);
        press_valid = 1'b0;
        temp_valid = 1'b0;
    endtask

    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        rdchk(8'h00, 10, {8'h5A, 72'h0}, 10'h002);
        $display("test reset_values done");
        sample(24'h012345, 1'b1, 16'h0ABC, 1'b1);
        rdchk(8'h00, 6, 48'h5A123450ABC0, 10'h002);
        sample(24'h012349, 1'b1, 16'h0ABC, 1'b0);
        rdchk(8'h07, 3, 24'h000040, 10'h000);
        $display("test pressure done");
        altitude = 1'b1;
        sample(24'h000100, 1'b1, 16'h0000, 1'b0);
        sample(24'h0000F0, 1'b1, 16'h0000, 1'b0);
        rdchk(8'h01, 3, 24'h000F00, 10'h001);
        rdchk(8'h07, 3, 24'hFFFF00, 10'h000);
        $display("test altitude done");
        raw = 1'b1;
        sample(24'hA5C3E7, 1'b1, 16'h9D1B, 1'b1);
        rdchk(8'h01, 5, 40'hA5C3E79D1B, 10'h001);
        rdchk(8'h07, 3, 24'hFFFF00, 10'h000);
        u_host.write(8'h01, 8'h77);
        rdchk(8'h01, 1, 8'hA5, 10'h001);
        $display("test raw_and_write done");
        raw = 1'b0;
        fifo_mode = 2'h1;
        sample(24'h0000E0, 1'b1, 16'h0000, 1'b0);
        sample(24'h0000D8, 1'b1, 16'h0000, 1'b0);
        rdchk(8'h07, 3, 24'hFFFF80, 10'h000);
        for (int m = 1; m < 4; m++) begin
            fifo_mode = m[1:0];
            rdchk(8'h01, 2, 16'h3C3C, 10'h000);
            rdchk(8'h02, 4, 32'h0, 10'h000);
        end
        $display("test fifo_modes done");
        print_verdict();
    end
endmodule
